//--- shared/acc_pkg.sv
`default_nettype none
package acc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CFG_ZERO  = 8'h62;
   localparam logic [7:0] IDX_CFG_ONE   = 8'h65;
   localparam logic [7:0] IDX_AVERAGING = 8'h68;
   localparam logic [7:0] IDX_STATUS    = 8'h6a;
   localparam logic [7:0] IDX_PIN_CFG   = 8'h6b;
   localparam logic [7:0] IDX_SOFT_TRIG = 8'h6c;
   localparam logic [7:0] IDX_EVT_STAT  = 8'h70;
   localparam logic [7:0] IDX_EVT_MASK  = 8'h71;

   // Reset values
   localparam logic [7:0] RST_CFG_ZERO  = 8'h01;
   localparam logic [7:0] RST_CFG_ONE   = 8'h01;
   localparam logic [7:0] RST_AVERAGING = 8'h61;
   localparam logic [7:0] RST_PIN_CFG   = 8'h00;
   localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
   localparam logic [7:0] RST_EVT       = 8'h00;

   // Field positions
   localparam int POS_FG_ENABLE    = 0;
   localparam int POS_BG_ENABLE    = 1;
   localparam int POS_OFFSET_REF   = 2;
   localparam int POS_OFFSET_AVG   = 4;
   localparam int POS_LIN_AVG      = 0;
   localparam int POS_TRIG_SOURCE  = 0;
   localparam int POS_STATUS_SEL   = 1;
   localparam int POS_SOFT_TRIG    = 0;
   localparam int POS_FG_COMPLETE  = 0;
   localparam int POS_BG_STOPPED   = 1;
   localparam int POS_STAT_CODE    = 2;
   localparam int POS_EVT_FG       = 0;
   localparam int POS_EVT_STOP     = 1;
   localparam int POS_EVT_ALARM    = 2;

   // Status pin source codes
   localparam logic [1:0] PIN_SEL_FG    = 2'h0;
   localparam logic [1:0] PIN_SEL_STOP  = 2'h1;
   localparam logic [1:0] PIN_SEL_ALARM = 2'h2;
   localparam logic [1:0] PIN_SEL_LOW   = 2'h3;

   // Report from the calibration engine, same clock
   typedef struct packed {
      logic       fgFinished;
      logic       bgHalted;
      logic [2:0] statusCode;
      logic       alarm;
   } acc_engine_t;

   // Settings handed to the calibration engine
   typedef struct packed {
      logic       foregroundEnable;
      logic       backgroundEnable;
      logic       offsetUseSpare;
      logic [2:0] offsetAveragingDepth;
      logic [2:0] linearityAveragingDepth;
      logic       calibrationTrigger;
   } acc_setting_t;

endpackage : acc_pkg
`default_nettype wire

//--- rtl/acc_regs.sv
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module acc_regs (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [11:0]          wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire acc_pkg::acc_engine_t engineReport,
   input  wire logic                 hardwareTriggerPin,
   output acc_pkg::acc_setting_t     engineSetting,
   output logic                      calibrationStatusPin,
   output logic                      irq
);

   // Bus decode
   logic        busReq;
   logic        busDone;
   logic        busWr;
   logic        lowLane;
   logic [7:0]  regIdx;
   logic        inRange;
   logic [7:0]  wrByte;

   function automatic logic hit(input logic [7:0] idx,
                                input logic [7:0] want);
      hit = (idx == want);
   endfunction : hit

   assign busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Writes land at the edge where the master sees ack
   assign busDone = wb_cyc_i & wb_stb_i & wb_ack_o;
   assign busWr   = busDone & wb_we_i & lowLane;
   assign lowLane = wb_sel_i[0];
   assign regIdx  = wb_adr_i[9:2];
   assign inRange = (wb_adr_i[11:10] == 2'h0);
   assign wrByte  = wb_dat_i[7:0];

   logic wrCfgZero;
   logic wrCfgOne;
   logic wrAvg;
   logic wrPin;
   logic wrSoft;
   logic wrEvtStat;
   logic wrEvtMask;

   assign wrCfgZero = busWr & inRange
                    & hit(regIdx, acc_pkg::IDX_CFG_ZERO);
   assign wrCfgOne  = busWr & inRange
                    & hit(regIdx, acc_pkg::IDX_CFG_ONE);
   assign wrAvg     = busWr & inRange
                    & hit(regIdx, acc_pkg::IDX_AVERAGING);
   assign wrPin     = busWr & inRange
                    & hit(regIdx, acc_pkg::IDX_PIN_CFG);
   assign wrSoft    = busWr & inRange
                    & hit(regIdx, acc_pkg::IDX_SOFT_TRIG);
   assign wrEvtStat = busWr & inRange
                    & hit(regIdx, acc_pkg::IDX_EVT_STAT);
   assign wrEvtMask = busWr & inRange
                    & hit(regIdx, acc_pkg::IDX_EVT_MASK);

   // Writable registers; reserved bits are stored as written
   logic [7:0] cfgZero_q;
   logic [7:0] cfgOne_q;
   logic [7:0] avg_q;
   logic [7:0] pinCfg_q;
   logic [7:0] softTrig_q;
   logic [7:0] evtMask_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfgZero_q  <= acc_pkg::RST_CFG_ZERO;
         cfgOne_q   <= acc_pkg::RST_CFG_ONE;
         avg_q      <= acc_pkg::RST_AVERAGING;
         pinCfg_q   <= acc_pkg::RST_PIN_CFG;
         softTrig_q <= acc_pkg::RST_SOFT_TRIG;
         evtMask_q  <= acc_pkg::RST_EVT;
      end else begin
         if (wrCfgZero) cfgZero_q  <= wrByte;
         if (wrCfgOne)  cfgOne_q   <= wrByte;
         if (wrAvg)     avg_q      <= wrByte;
         if (wrPin)     pinCfg_q   <= wrByte;
         if (wrSoft)    softTrig_q <= wrByte;
         if (wrEvtMask) evtMask_q  <= wrByte;
      end
   end

   // Field views
   logic       fgEnable;
   logic       bgEnable;
   logic       offsetRef;
   logic [2:0] offsetAvg;
   logic [2:0] linAvg;
   logic       trigSource;
   logic [1:0] pinSel;
   logic       softTrigBit;

   assign fgEnable    = cfgZero_q[acc_pkg::POS_FG_ENABLE];
   assign bgEnable    = cfgZero_q[acc_pkg::POS_BG_ENABLE];
   assign offsetRef   = cfgOne_q[acc_pkg::POS_OFFSET_REF];
   assign offsetAvg   = avg_q[acc_pkg::POS_OFFSET_AVG +: 3];
   assign linAvg      = avg_q[acc_pkg::POS_LIN_AVG +: 3];
   assign trigSource  = pinCfg_q[acc_pkg::POS_TRIG_SOURCE];
   assign pinSel      = pinCfg_q[acc_pkg::POS_STATUS_SEL +: 2];
   assign softTrigBit = softTrig_q[acc_pkg::POS_SOFT_TRIG];

   // Hardware trigger pin: three stages, change taken on agreement
   logic trigSync1_q;
   logic trigSync2_q;
   logic trigSync3_q;
   logic hwTrig_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         trigSync1_q <= 1'b0;
         trigSync2_q <= 1'b0;
         trigSync3_q <= 1'b0;
         hwTrig_q    <= 1'b0;
      end else begin
         trigSync1_q <= hardwareTriggerPin;
         trigSync2_q <= trigSync1_q;
         trigSync3_q <= trigSync2_q;
         if (trigSync2_q == trigSync3_q) hwTrig_q <= trigSync3_q;
      end
   end

   // Trigger source choice
   logic trigger_d;
   assign trigger_d = trigSource ? hwTrig_q : softTrigBit;

   // Calibration status flags from the engine; fgComplete forced while fgEnable is 0, bgStopped follows it while bgEnable is 0
   logic       fgComplete_d;
   logic       bgStopped_d;
   logic       fgComplete_q;
   logic       bgStopped_q;
   logic [2:0] statCode_q;
   logic       alarm_q;

   assign fgComplete_d = engineReport.fgFinished | ~fgEnable;
   assign bgStopped_d  = bgEnable ? engineReport.bgHalted
                                  : fgComplete_d;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fgComplete_q <= 1'b0;
         bgStopped_q  <= 1'b0;
         statCode_q   <= 3'h0;
         alarm_q      <= 1'b0;
      end else begin
         fgComplete_q <= fgComplete_d;
         bgStopped_q  <= bgStopped_d;
         statCode_q   <= engineReport.statusCode;
         alarm_q      <= engineReport.alarm;
      end
   end

   logic [7:0] statusByte;
   assign statusByte = {3'h0, statCode_q, bgStopped_q, fgComplete_q};

   // Status pin routing
   logic pin_d;
   always_comb begin
      case (pinSel)
         acc_pkg::PIN_SEL_FG:    pin_d = fgComplete_q;
         acc_pkg::PIN_SEL_STOP:  pin_d = bgStopped_q;
         acc_pkg::PIN_SEL_ALARM: pin_d = alarm_q;
         acc_pkg::PIN_SEL_LOW:   pin_d = 1'b0;
         default:                pin_d = 1'b0;
      endcase
   end

   // Events: rising edges of the flags; set wins over clear
   logic [7:0] evtRise;
   logic [7:0] evtClr;
   logic [7:0] evtStat_d;
   logic [7:0] evtStat_q;

   assign evtRise   = {5'h0,
                       engineReport.alarm & ~alarm_q,
                       bgStopped_d & ~bgStopped_q,
                       fgComplete_d & ~fgComplete_q};
   assign evtClr    = wrEvtStat ? wrByte : 8'h00;
   assign evtStat_d = (evtStat_q & ~evtClr) | evtRise;

   always_ff @(posedge mclk) begin
      if (!rst_n) evtStat_q <= acc_pkg::RST_EVT;
      else        evtStat_q <= evtStat_d;
   end

   // Read mux; unmapped addresses read zero
   logic [7:0] rdByte;
   always_comb begin
      rdByte = 8'h00;
      if (inRange) begin
         case (regIdx)
            acc_pkg::IDX_CFG_ZERO:  rdByte = cfgZero_q;
            acc_pkg::IDX_CFG_ONE:   rdByte = cfgOne_q;
            acc_pkg::IDX_AVERAGING: rdByte = avg_q;
            acc_pkg::IDX_STATUS:    rdByte = statusByte;
            acc_pkg::IDX_PIN_CFG:   rdByte = pinCfg_q;
            acc_pkg::IDX_SOFT_TRIG: rdByte = softTrig_q;
            acc_pkg::IDX_EVT_STAT:  rdByte = evtStat_q;
            acc_pkg::IDX_EVT_MASK:  rdByte = evtMask_q;
            default:                rdByte = 8'h00;
         endcase
      end
   end

   // Bus answer: one cycle after the request, one-cycle ack
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= busReq;
         if (busReq) wb_dat_o <= {24'h00_0000, rdByte};
      end
   end

   // Engine settings, status pin and interrupt from flip-flops
   acc_pkg::acc_setting_t setting_d;

   assign setting_d.offsetUseSpare          = offsetRef;
   assign setting_d.offsetAveragingDepth    = offsetAvg;
   assign setting_d.linearityAveragingDepth = linAvg;
   assign setting_d.foregroundEnable        = fgEnable;
   assign setting_d.backgroundEnable        = bgEnable;
   assign setting_d.calibrationTrigger      = trigger_d;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         engineSetting        <= '0;
         calibrationStatusPin <= 1'b0;
         irq                  <= 1'b0;
      end else begin
         engineSetting        <= setting_d;
         calibrationStatusPin <= pin_d;
         irq                  <= |(evtStat_q & evtMask_q);
      end
   end

endmodule : acc_regs
`default_nettype wire

//--- verification/acc_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module acc_regs_asserts (
   input wire logic                  mclk,
   input wire logic                  rst_n,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [11:0]           wb_adr_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   input wire acc_pkg::acc_engine_t  engineReport,
   input wire logic                  hardwareTriggerPin,
   input wire acc_pkg::acc_setting_t engineSetting,
   input wire logic                  calibrationStatusPin
);
   // Shadow of the pin configuration, stored at the acked edge
   logic [2:0]      pinCfg_q;
   wire logic       pinWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                            && wb_sel_i[0] && wb_adr_i == 12'h1ac;
   wire logic [1:0] pinSel = pinCfg_q[2:1];
   always_ff @(posedge mclk)
      if (!rst_n)
         pinCfg_q <= 3'h0;
      else if (pinWr)
         pinCfg_q <= wb_dat_i[2:0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence sFg;
      (pinSel == acc_pkg::PIN_SEL_FG && engineSetting.foregroundEnable
       && $stable(engineReport.fgFinished)) [*3];
   endsequence
   sequence sStop;
      (pinSel == acc_pkg::PIN_SEL_STOP && engineSetting.backgroundEnable
       && $stable(engineReport.bgHalted)) [*3];
   endsequence
   sequence sAlarm;
      (pinSel == acc_pkg::PIN_SEL_ALARM && $stable(engineReport.alarm)) [*3];
   endsequence
   sequence sHw;
      (pinCfg_q[0] && $stable(hardwareTriggerPin)) [*6];
   endsequence
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not acknowledged");
   chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == '0)
      else $error("upper read bits not zero");
   chk_pin_low: assert property ((pinSel == acc_pkg::PIN_SEL_LOW) [*3]
      |-> !calibrationStatusPin) else $error("status pin not low");
   chk_pin_fg: assert property (sFg
      |-> calibrationStatusPin == engineReport.fgFinished)
      else $error("status pin not foreground flag");
   chk_pin_stop: assert property (sStop
      |-> calibrationStatusPin == engineReport.bgHalted)
      else $error("status pin not stopped flag");
   chk_pin_alarm: assert property (sAlarm
      |-> calibrationStatusPin == engineReport.alarm)
      else $error("status pin not alarm");
   chk_trig_hw: assert property (sHw
      |-> engineSetting.calibrationTrigger == hardwareTriggerPin)
      else $error("trigger not from pin");
endmodule : acc_regs_asserts
bind acc_regs acc_regs_asserts u_chk (
   .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .engineReport(engineReport), .hardwareTriggerPin(hardwareTriggerPin),
   .engineSetting(engineSetting),
   .calibrationStatusPin(calibrationStatusPin));
`default_nettype wire

//--- verification/acc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acc_regs_tb;
   logic                  mclk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  cyc = 1'b0;
   logic                  stb = 1'b0;
   logic                  we = 1'b0;
   logic [11:0]           adr = 12'h000;
   logic [3:0]            sel = 4'h0;
   logic [31:0]           wdat = 32'h0000_0000;
   logic [31:0]           rdat;
   logic                  ack;
   logic                  hwPin = 1'b0;
   logic                  statPin;
   logic                  irq;
   acc_pkg::acc_engine_t  eng = '0;
   acc_pkg::acc_setting_t set;
   int                    miscompares = 0;
   int                    totalChecks = 0;
   acc_regs DUT (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .engineReport(eng),
      .hardwareTriggerPin(hwPin), .engineSetting(set),
      .calibrationStatusPin(statPin), .irq(irq));
   initial forever #5 mclk = ~mclk;
   task tally_and_finish;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
           output logic [31:0] q);
      int n;
      @(posedge mclk);
      {cyc, stb, we} <= {2'b11, w};
      adr <= {2'b00, idx, 2'b00};
      wdat <= {24'h00_0000, d};
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      {cyc, stb} <= 2'b00;
      if (n >= 20) begin
         miscompares++;
         tally_and_finish;
      end
   endtask : wb
   task wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, idx, d, q);
      repeat (3) @(posedge mclk);
   endtask : wr
   task rd(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk(q, exp);
   endtask : rd
   // Engine report: fg, halted, code, alarm
   task eng_set(input logic [5:0] v);
      @(posedge mclk);
      eng <= v;
      repeat (4) @(posedge mclk);
   endtask : eng_set
   task t_reset;
      rd(acc_pkg::IDX_CFG_ONE, 32'h0000_0001);
      rd(acc_pkg::IDX_AVERAGING, 32'h0000_0061);
      rd(acc_pkg::IDX_STATUS, 32'h0000_0000);
      rd(acc_pkg::IDX_PIN_CFG, 32'h0000_0000);
      rd(8'h7f, 32'h0000_0000);
      chk(32'(set.offsetAveragingDepth), 32'h6);
      chk(32'(set.linearityAveragingDepth), 32'h1);
      chk(32'(set.calibrationTrigger), 32'h1);
      $display("t_reset done");
   endtask : t_reset
   task t_fields;
      wr(acc_pkg::IDX_AVERAGING, 8'h35);
      chk(32'(set.offsetAveragingDepth), 32'h3);
      chk(32'(set.linearityAveragingDepth), 32'h5);
      wr(acc_pkg::IDX_CFG_ZERO, 8'h03);
      wr(acc_pkg::IDX_CFG_ONE, 8'h05);
      chk(32'(set.backgroundEnable), 32'h1);
      chk(32'(set.offsetUseSpare), 32'h1);
      wr(acc_pkg::IDX_CFG_ONE, 8'h01);
      chk(32'(set.offsetUseSpare), 32'h0);
      wr(acc_pkg::IDX_STATUS, 8'h1f);
      rd(acc_pkg::IDX_STATUS, 32'h0000_0000);
      $display("t_fields done");
   endtask : t_fields
   task t_status;
      eng_set(6'h1a);
      rd(acc_pkg::IDX_STATUS, 32'h0000_0016);
      eng_set(6'h0a);
      rd(acc_pkg::IDX_STATUS, 32'h0000_0014);
      eng_set(6'h20);
      rd(acc_pkg::IDX_STATUS, 32'h0000_0001);
      wr(acc_pkg::IDX_CFG_ZERO, 8'h00);
      eng_set(6'h00);
      rd(acc_pkg::IDX_STATUS, 32'h0000_0003);
      $display("t_status done");
   endtask : t_status
   task t_pin;
      logic [5:0] v;
      logic       e;
      wr(acc_pkg::IDX_CFG_ZERO, 8'h03);
      for (int p = 0; p < 2; p++) begin
         v = (p == 0) ? 6'h21 : 6'h10;
         eng_set(v);
         for (int c = 0; c < 4; c++) begin
            wr(acc_pkg::IDX_PIN_CFG, 8'(c << 1));
            e = c == 0 ? v[5] : c == 1 ? v[4] : c == 2 ? v[0] : 1'b0;
            chk(32'(statPin), 32'(e));
         end
      end
      $display("t_pin done");
   endtask : t_pin
   task t_irq;
      wr(acc_pkg::IDX_EVT_STAT, 8'h07);
      wr(acc_pkg::IDX_EVT_MASK, 8'h02);
      eng_set(6'h20);
      chk(32'(irq), 32'h0);
      rd(acc_pkg::IDX_EVT_STAT, 32'h0000_0001);
      wr(acc_pkg::IDX_EVT_MASK, 8'h01);
      chk(32'(irq), 32'h1);
      wr(acc_pkg::IDX_EVT_STAT, 8'h01);
      chk(32'(irq), 32'h0);
      rd(acc_pkg::IDX_EVT_STAT, 32'h0000_0000);
      $display("t_irq done");
   endtask : t_irq
   task t_trig;
      wr(acc_pkg::IDX_PIN_CFG, 8'h00);
      chk(32'(set.calibrationTrigger), 32'h1);
      wr(acc_pkg::IDX_SOFT_TRIG, 8'h00);
      hwPin <= 1'b1;
      repeat (8) @(posedge mclk);
      chk(32'(set.calibrationTrigger), 32'h0);
      wr(acc_pkg::IDX_PIN_CFG, 8'h01);
      repeat (6) @(posedge mclk);
      chk(32'(set.calibrationTrigger), 32'h1);
      wr(acc_pkg::IDX_SOFT_TRIG, 8'h01);
      hwPin <= 1'b0;
      repeat (8) @(posedge mclk);
      chk(32'(set.calibrationTrigger), 32'h0);
      $display("t_trig done");
   endtask : t_trig
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_reset;
      t_fields;
      t_status;
      t_pin;
      t_irq;
      t_trig;
      tally_and_finish;
   end
endmodule : acc_regs_tb
`default_nettype wire
